//--- rtl/core_irq_pkg.sv
// Shared constants and carrier types for the core interrupt control block.
// Assumes one system clock domain and a core bus with a 9-bit banked address.
package core_irq_pkg;

   // Core register bus geometry.
   localparam int ADDR_W = 9;
   localparam int DATA_W = 8;

   // The control register decodes on the low seven address bits so that it
   // mirrors into every data bank (0x00B, 0x08B, 0x10B, 0x18B).
   localparam int                BANK_OFS_W       = 7;
   localparam logic [ADDR_W-1:0] IRQ_CONTROL_ADDR = 9'h08b;
   localparam logic [BANK_OFS_W-1:0] IRQ_CONTROL_OFS = IRQ_CONTROL_ADDR[BANK_OFS_W-1:0];

   // Field positions inside the control register.
   localparam int GLOBAL_EN_BIT   = 7;
   localparam int PERIPH_EN_BIT   = 6;
   localparam int TICK_EN_BIT     = 5;
   localparam int EXT_EN_BIT      = 4;
   localparam int CHANGE_EN_BIT   = 3;
   localparam int TICK_FLAG_BIT   = 2;
   localparam int EXT_FLAG_BIT    = 1;
   localparam int CHANGE_FLAG_BIT = 0;

   // Reset values of the reset-driven fields.
   localparam logic [DATA_W-1:0] READ_IDLE = 8'h00;
   localparam logic              EN_RESET  = 1'b0;
   localparam logic              FLAG_RESET = 1'b0;

   // Monitored pin widths: six pins of the first port, four of the second.
   localparam int FIRST_PORT_W  = 6;
   localparam int SECOND_PORT_W = 4;

   // One access from the core to its register space.
   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } core_bus_req_t;

   // Pin-side event sources.
   typedef struct packed {
      logic                     ext_irq_pin;
      logic [FIRST_PORT_W-1:0]  first_io_port;
      logic [SECOND_PORT_W-1:0] second_io_port;
   } irq_pins_t;

endpackage : core_irq_pkg

//--- rtl/pin_sync.sv
// Three-stage synchroniser with an agreement filter for pin inputs.
// Assumes the inputs are asynchronous to i_sys_clk.
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             i_sys_clk,
   input  wire logic             i_rst_n,
   input  wire logic [WIDTH-1:0] i_pin,
   output var  logic [WIDTH-1:0] o_level,
   output var  logic             o_settled
);

   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] stage2_r;
   logic [WIDTH-1:0] stage3_r;

   // The first stage feeds only the second, so a metastable value never
   // reaches a comparator.
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         meta_r   <= '0;
         stage2_r <= '0;
         stage3_r <= '0;
      end
      else
      begin
         meta_r   <= i_pin;
         stage2_r <= meta_r;
         stage3_r <= stage2_r;
      end
   end

   // A bit is accepted only once the second and third stages agree.
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_level <= '0;
      end
      else
      begin
         for (int i = 0; i < WIDTH; i++)
         begin
            if (stage2_r[i] == stage3_r[i])
            begin
               o_level[i] <= stage3_r[i];
            end
         end
      end
   end

   // Settled marks that every stage holds real pin data; before that the
   // accepted level is only the reset constant and must not count as a change.
   logic [1:0] fill_r;

   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         fill_r    <= 2'b00;
         o_settled <= 1'b0;
      end
      else
      begin
         if (fill_r != 2'b11)
         begin
            fill_r <= fill_r + 2'b01;
         end
         o_settled <= (fill_r == 2'b11);
      end
   end

endmodule // pin_sync

`default_nettype wire

//--- rtl/core_interrupt_control.sv
// Core interrupt control register with its event flags and request output.
// Assumes the core accesses registers on i_sys_clk through i_bus, the timer
// overflow pulse comes from logic on the same clock, and pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none

module core_interrupt_control (
   input  wire logic                                     i_sys_clk,
   input  wire logic                                     i_rst_n,
   input  wire core_irq_pkg::core_bus_req_t              i_bus,
   input  wire core_irq_pkg::irq_pins_t                  i_pins,
   input  wire logic                                     i_tick_overflow,
   input  wire logic                                     i_ext_rising_edge,
   input  wire logic [core_irq_pkg::FIRST_PORT_W-1:0]    i_first_port_change_mask,
   input  wire logic [core_irq_pkg::SECOND_PORT_W-1:0]   i_second_port_change_mask,
   input  wire logic                                     i_periph_irq_pending,
   output var  logic [core_irq_pkg::DATA_W-1:0]          o_rd_data,
   output var  logic [core_irq_pkg::DATA_W-1:0]          o_irq_control_reg,
   output var  logic                                     o_irq_req
);

   localparam int PIN_W = 1 + core_irq_pkg::FIRST_PORT_W + core_irq_pkg::SECOND_PORT_W;

   // Control and flag state.
   logic global_irq_enable_r;
   logic periph_group_irq_enable_r;
   logic tick_overflow_irq_enable_r;
   logic ext_pin_irq_enable_r;
   logic pin_change_irq_enable_r;
   logic tick_overflow_flag_r;
   logic ext_pin_flag_r;
   logic pin_change_flag_r;

   // Synchronised pin view.
   logic [PIN_W-1:0] pin_level;
   logic             pin_settled;
   logic [PIN_W-1:0] pin_prev_r;
   logic             pin_prev_ok_r;

   // Decoded core access.
   logic             reg_hit;
   logic             reg_wr;
   logic             reg_rd;
   logic [core_irq_pkg::DATA_W-1:0] reg_value;

   // Events detected this cycle.
   logic ext_event;
   logic change_event;
   logic [core_irq_pkg::FIRST_PORT_W-1:0]  first_diff;
   logic [core_irq_pkg::SECOND_PORT_W-1:0] second_diff;
   logic request_nxt;

   // Per-source request terms, each a flag paired with its own enable.
   logic tick_term;
   logic ext_term;
   logic change_term;
   logic periph_term;

   // All monitored pins share one synchroniser so they settle together.
   // A single settled flag then covers every pin, and no pin can report a
   // change while another is still filling its stages.
   pin_sync #(
      .WIDTH (PIN_W)
   ) u_pin_sync (
      .i_sys_clk (i_sys_clk),
      .i_rst_n   (i_rst_n),
      .i_pin     ({i_pins.ext_irq_pin, i_pins.first_io_port, i_pins.second_io_port}),
      .o_level   (pin_level),
      .o_settled (pin_settled)
   );

   // Only the low bank offset is decoded, so every bank sees the same register.
   // The two bank-select bits are ignored on purpose; any other offset is
   // refused, so writes elsewhere leave the register untouched.
   assign reg_hit = (i_bus.addr[core_irq_pkg::BANK_OFS_W-1:0] == core_irq_pkg::IRQ_CONTROL_OFS);
   assign reg_wr  = i_bus.wr & reg_hit;
   assign reg_rd  = i_bus.rd & reg_hit;

   // Assemble the register image, global enable at the top down to the change
   // flag at bit 0. Every one of the eight positions holds live state.
   always_comb
   begin
      reg_value = core_irq_pkg::READ_IDLE;
      reg_value[core_irq_pkg::GLOBAL_EN_BIT]   = global_irq_enable_r;
      reg_value[core_irq_pkg::PERIPH_EN_BIT]   = periph_group_irq_enable_r;
      reg_value[core_irq_pkg::TICK_EN_BIT]     = tick_overflow_irq_enable_r;
      reg_value[core_irq_pkg::EXT_EN_BIT]      = ext_pin_irq_enable_r;
      reg_value[core_irq_pkg::CHANGE_EN_BIT]   = pin_change_irq_enable_r;
      reg_value[core_irq_pkg::TICK_FLAG_BIT]   = tick_overflow_flag_r;
      reg_value[core_irq_pkg::EXT_FLAG_BIT]    = ext_pin_flag_r;
      reg_value[core_irq_pkg::CHANGE_FLAG_BIT] = pin_change_flag_r;
   end

   // Remember the previous accepted pin levels to spot edges and changes.
   // Both registers restart on reset so the first real sample is never
   // compared against a stale level.
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         pin_prev_r    <= '0;
         pin_prev_ok_r <= 1'b0;
      end
      else
      begin
         pin_prev_r    <= pin_level;
         pin_prev_ok_r <= pin_settled;
      end
   end

   // The external pin fires on the selected edge only; comparing against the
   // previous level needs both samples to be real pin data.
   always_comb
   begin
      ext_event = 1'b0;
      if (pin_prev_ok_r)
      begin
         if (i_ext_rising_edge)
         begin
            ext_event = pin_level[PIN_W-1] & ~pin_prev_r[PIN_W-1];
         end
         else
         begin
            ext_event = ~pin_level[PIN_W-1] & pin_prev_r[PIN_W-1];
         end
      end
   end

   // Any masked pin of either port that differs from its last level counts.
   // The first port's mask is an extra gate of this block; an all-ones mask
   // watches all six pins.
   // The second port watches only pins whose change mask bit is set.
   assign first_diff   = (pin_level[PIN_W-2 -: core_irq_pkg::FIRST_PORT_W]
                          ^ pin_prev_r[PIN_W-2 -: core_irq_pkg::FIRST_PORT_W])
                         & i_first_port_change_mask;
   assign second_diff  = (pin_level[core_irq_pkg::SECOND_PORT_W-1:0]
                          ^ pin_prev_r[core_irq_pkg::SECOND_PORT_W-1:0])
                         & i_second_port_change_mask;
   assign change_event = pin_prev_ok_r & ((|first_diff) | (|second_diff));

   // Enable bits: plain read/write storage cleared by every reset.
   // A write always replaces all five enables together; there is no per-bit
   // write mask, so software updates them by read, modify and write.
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         global_irq_enable_r        <= core_irq_pkg::EN_RESET;
         periph_group_irq_enable_r  <= core_irq_pkg::EN_RESET;
         tick_overflow_irq_enable_r <= core_irq_pkg::EN_RESET;
         ext_pin_irq_enable_r       <= core_irq_pkg::EN_RESET;
         pin_change_irq_enable_r    <= core_irq_pkg::EN_RESET;
      end
      else if (reg_wr)
      begin
         global_irq_enable_r        <= i_bus.wdata[core_irq_pkg::GLOBAL_EN_BIT];
         periph_group_irq_enable_r  <= i_bus.wdata[core_irq_pkg::PERIPH_EN_BIT];
         tick_overflow_irq_enable_r <= i_bus.wdata[core_irq_pkg::TICK_EN_BIT];
         ext_pin_irq_enable_r       <= i_bus.wdata[core_irq_pkg::EXT_EN_BIT];
         pin_change_irq_enable_r    <= i_bus.wdata[core_irq_pkg::CHANGE_EN_BIT];
      end
   end

   // Timer overflow flag. A rollover in the same cycle as a software write of
   // zero still sets the flag, so no overflow is lost. The timer itself lives
   // outside and keeps its count over reset; only the flag is cleared here.
   // Software should load the timer before it clears this flag after a reset,
   // or an overflow counted before the reset can be reported again.
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         tick_overflow_flag_r <= core_irq_pkg::FLAG_RESET;
      end
      else if (i_tick_overflow)
      begin
         tick_overflow_flag_r <= 1'b1;
      end
      else if (reg_wr)
      begin
         tick_overflow_flag_r <= i_bus.wdata[core_irq_pkg::TICK_FLAG_BIT];
      end
   end

   // External pin flag; the event is caught whatever the enables hold.
   // The edge is judged on the filtered level, so a pin pulse shorter than
   // about two clocks can be missed; slower pin activity is always seen.
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         ext_pin_flag_r <= core_irq_pkg::FLAG_RESET;
      end
      else if (ext_event)
      begin
         ext_pin_flag_r <= 1'b1;
      end
      else if (reg_wr)
      begin
         ext_pin_flag_r <= i_bus.wdata[core_irq_pkg::EXT_FLAG_BIT];
      end
   end

   // Port change flag. It has no reset on purpose: its value survives reset
   // and is unknown after power-up, so software must clear it before use.
   // A pin change and a write of zero in one cycle leave the flag set.
   always_ff @(posedge i_sys_clk)
   begin
      if (change_event)
      begin
         pin_change_flag_r <= 1'b1;
      end
      else if (reg_wr)
      begin
         pin_change_flag_r <= i_bus.wdata[core_irq_pkg::CHANGE_FLAG_BIT];
      end
   end

   // Each source counts only while its flag and its own enable are both set.
   assign tick_term   = tick_overflow_irq_enable_r & tick_overflow_flag_r;
   assign ext_term    = ext_pin_irq_enable_r & ext_pin_flag_r;
   assign change_term = pin_change_irq_enable_r & pin_change_flag_r;

   // The peripheral group arrives already combined from its own flag and
   // enable pairs; this block gates it with bit 6 and then with the global enable.
   assign periph_term = periph_group_irq_enable_r & i_periph_irq_pending;

   // Request logic. Global enable is the last gate, so clearing it masks every
   // source at once and disturbs no flag. A stale flag raises a request as soon
   // as its enable is written, which is why software clears flags before enabling.
   always_comb
   begin
      request_nxt = tick_term | ext_term | change_term | periph_term;
      request_nxt = request_nxt & global_irq_enable_r;
   end

   // Registered request to the core; one cycle behind the register state.
   // Registering it keeps the request free of decode glitches, at the cost of
   // one clock of latency after the flag and enables line up.
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_irq_req <= 1'b0;
      end
      else
      begin
         o_irq_req <= request_nxt;
      end
   end

   // Read port: data appears the cycle after the read strobe and returns to
   // zero otherwise, so an unmapped read answers zero.
   // A write and a read in one cycle return the value from before the write.
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_rd_data <= core_irq_pkg::READ_IDLE;
      end
      else if (reg_rd)
      begin
         o_rd_data <= reg_value;
      end
      else
      begin
         o_rd_data <= core_irq_pkg::READ_IDLE;
      end
   end

   // Live copy of the register for the core's own use. The change flag bit
   // can be unknown until software first writes it.
   // It lags the internal state by the same one cycle as the request output.
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_irq_control_reg <= core_irq_pkg::READ_IDLE;
      end
      else
      begin
         o_irq_control_reg <= reg_value;
      end
   end

endmodule // core_interrupt_control

`default_nettype wire

//--- sim/core_irq_ctl_assertions.sv
// Concurrent checks on the core interrupt control ports.
// Assumes one clock domain; bound to the top module below.
`timescale 1ns/1ps
`default_nettype none
module irq_ctl_checker (
   input wire logic                        i_sys_clk,
   input wire logic                        i_rst_n,
   input wire core_irq_pkg::core_bus_req_t i_bus,
   input wire logic                        i_tick_overflow,
   input wire logic                        i_periph_irq_pending,
   input wire logic [7:0]                  o_rd_data,
   input wire logic [7:0]                  o_irq_control_reg,
   input wire logic                        o_irq_req
);
   logic       wr_hit;
   logic       rd_hit;
   logic [7:0] r;
   // Any bank hits the register, so decode on the low seven bits only.
   assign wr_hit = i_bus.wr && (i_bus.addr[6:0] == core_irq_pkg::IRQ_CONTROL_OFS);
   assign rd_hit = i_bus.rd && (i_bus.addr[6:0] == core_irq_pkg::IRQ_CONTROL_OFS);
   assign r = o_irq_control_reg;
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);
   chk_gie_blocks_req:
      assert property (!r[7] |-> !o_irq_req) else $error("request with global enable clear");
   chk_req_exact_term:
      assert property (o_irq_req == (r[7] && ((r[5] && r[2]) || (r[4] && r[1]) || (r[3] && r[0])
         || (r[6] && $past(i_periph_irq_pending))))) else $error("request term wrong");
   chk_tick_sets_flag:
      assert property (i_tick_overflow |-> ##2 r[2]) else $error("overflow flag not set");
   chk_tick_flag_holds:
      assert property ($past(r[2]) && !r[2] |-> $past(wr_hit && !i_bus.wdata[2], 2))
         else $error("overflow flag cleared without write");
   chk_ext_flag_holds:
      assert property ($past(r[1]) && !r[1] |-> $past(wr_hit && !i_bus.wdata[1], 2))
         else $error("pin flag cleared without write");
   chk_tick_flag_cause:
      assert property (!$past(r[2]) && r[2] |-> ($past(i_tick_overflow, 2) || $past(wr_hit && i_bus.wdata[2], 2)))
         else $error("overflow flag set without cause");
   chk_write_image_lands:
      assert property (wr_hit ##1 !wr_hit |-> ##1 r[7:3] == $past(i_bus.wdata[7:3], 2))
         else $error("enables differ from write");
   chk_read_data_match:
      assert property (rd_hit |=> o_rd_data == r) else $error("read data differs");
   chk_other_read_zero:
      assert property (!rd_hit |=> o_rd_data == 8'h00) else $error("read data without hit");
   chk_reset_state_clear:
      assert property ($rose(i_rst_n) |-> r[7:1] == 7'h00 && !o_irq_req) else $error("reset state");
   cov_tick_req: cover property (i_tick_overflow ##2 o_irq_req);
   cov_high_bank: cover property (rd_hit && i_bus.addr[8:7] == 2'b11);
   cov_periph_req: cover property (o_irq_req && r[6] && !r[5]);
endmodule // irq_ctl_checker
bind core_interrupt_control irq_ctl_checker u_chk (
   .i_sys_clk(i_sys_clk),
   .i_rst_n(i_rst_n),
   .i_bus(i_bus),
   .i_tick_overflow(i_tick_overflow),
   .i_periph_irq_pending(i_periph_irq_pending),
   .o_rd_data(o_rd_data),
   .o_irq_control_reg(o_irq_control_reg),
   .o_irq_req(o_irq_req)
);
`default_nettype wire

//--- sim/core_req_model.sv
// Model of the core that takes interrupt requests.
// Assumes the request is a level on the system clock.
`timescale 1ns/1ps
`default_nettype none
module core_req_model (
   input  wire logic       i_sys_clk,
   input  wire logic       i_rst_n,
   input  wire logic       i_irq_req,
   output var  logic [7:0] o_taken
);
   logic req_r;
   // One entry per rising request; a held level is a single request.
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         req_r   <= 1'b0;
         o_taken <= 8'h00;
      end
      else
      begin
         req_r <= i_irq_req;
         if (i_irq_req && !req_r)
         begin
            o_taken <= o_taken + 8'h01;
         end
      end
   end
endmodule // core_req_model
`default_nettype wire

//--- sim/test_core_interrupt_control.sv
// Self-checking bench for the core interrupt control block.
// Drives bus, pins and timer pulse at the falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module test_core_interrupt_control;
   logic                        i_sys_clk = 1'b0;
   logic                        i_rst_n = 1'b0;
   core_irq_pkg::core_bus_req_t bus = '0;
   core_irq_pkg::irq_pins_t     pins = '0;
   logic                        tick = 1'b0;
   logic                        edge_sel = 1'b1;
   logic                        pend = 1'b0;
   logic [5:0]                  mask_a = 6'h3F;
   logic [3:0]                  mask_b = 4'hF;
   logic [7:0]                  rd_data;
   logic [7:0]                  ctl;
   logic                        req;
   logic [7:0]                  taken;
   logic                        prev_req = 1'b0;
   logic [7:0]                  rises = 8'h00;
   int                          checks = 0;
   int                          n_mismatch = 0;
   int                          cyc = 0;
   logic [8:0] bank [4] = '{9'h00b, 9'h08b, 9'h10b, 9'h18b};
   logic [7:0] pat [8] = '{8'hA5, 8'h92, 8'h89, 8'h7F, 8'hC0, 8'h80, 8'h87, 8'h00};

   core_interrupt_control uut (
      .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_bus(bus), .i_pins(pins),
      .i_tick_overflow(tick), .i_ext_rising_edge(edge_sel),
      .i_first_port_change_mask(mask_a), .i_second_port_change_mask(mask_b),
      .i_periph_irq_pending(pend), .o_rd_data(rd_data), .o_irq_control_reg(ctl), .o_irq_req(req));
   core_req_model core (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_irq_req(req), .o_taken(taken));

   // Free-running clock at 40 MHz.
   initial forever #12.5 i_sys_clk = ~i_sys_clk;

   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   // One bus cycle; the request stays up until the next call replaces it.
   task automatic acc(input logic w, input logic r, input logic [8:0] a, input logic [7:0] d);
      bus = '{wr: w, rd: r, addr: a, wdata: d};
      @(negedge i_sys_clk);
   endtask

   task automatic rd_chk(input logic [8:0] a, input logic [7:0] e);
      acc(1'b0, 1'b1, a, 8'h00);
      check(rd_data, e);
   endtask

   task automatic idle(input int n);
      bus = '0;
      repeat (n) @(negedge i_sys_clk);
   endtask

   // Tallies fresh requests so the core model's count can be compared.
   task automatic req_chk(input logic e);
      check({7'h00, req}, {7'h00, e});
      if (e && !prev_req)
         rises++;
      prev_req = e;
   endtask

   function automatic logic want(input logic [7:0] p, input logic pe);
      return p[7] && ((p[5] && p[2]) || (p[4] && p[1]) || (p[3] && p[0]) || (p[6] && pe));
   endfunction

   // Hang guard: the whole sequence needs well under a thousand cycles.
   always @(posedge i_sys_clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         n_mismatch++;
         finish_test();
      end
   end

   initial
   begin
      repeat (3) @(negedge i_sys_clk);
      i_rst_n = 1'b1;
      check({ctl[7:1], req}, 8'h00);
      acc(1'b1, 1'b0, 9'h08b, 8'h00);
      idle(8);
      for (int k = 0; k < 16; k++)
      begin
         pend = k[3];
         acc(1'b1, 1'b0, bank[k % 4], pat[k % 8]);
         rd_chk(bank[(k + 1) % 4], pat[k % 8]);
         req_chk(want(pat[k % 8], pend));
      end
      acc(1'b1, 1'b0, 9'h08c, 8'hFF);
      rd_chk(9'h08c, 8'h00);
      rd_chk(9'h18b, 8'h00);
      tick = 1'b1;
      acc(1'b1, 1'b0, 9'h08b, 8'h00);
      tick = 1'b0;
      rd_chk(9'h08b, 8'h04);
      for (int e = 0; e < 2; e++)
      begin
         edge_sel = e[0];
         pins.ext_irq_pin = ~e[0];
         idle(8);
         acc(1'b1, 1'b0, 9'h08b, 8'h00);
         pins.ext_irq_pin = e[0];
         idle(8);
         rd_chk(9'h10b, 8'h02);
      end
      mask_a = 6'h00;
      mask_b = 4'h0;
      acc(1'b1, 1'b0, 9'h08b, 8'h00);
      pins.first_io_port = 6'h3F;
      pins.second_io_port = 4'hF;
      idle(8);
      rd_chk(9'h08b, 8'h00);
      mask_b = 4'h1;
      pins.second_io_port = 4'hE;
      idle(8);
      rd_chk(9'h08b, 8'h01);
      acc(1'b1, 1'b0, 9'h08b, 8'h00);
      mask_a = 6'h20;
      pins.first_io_port = 6'h1F;
      idle(8);
      rd_chk(9'h08b, 8'h01);
      acc(1'b1, 1'b0, 9'h08b, 8'h00);
      acc(1'b1, 1'b0, 9'h08b, 8'hA0);
      tick = 1'b1;
      idle(1);
      tick = 1'b0;
      idle(1);
      req_chk(1'b1);
      // The core model samples the raised request one edge after its launch.
      idle(1);
      check(taken, rises);
      acc(1'b1, 1'b0, 9'h08b, 8'hFF);
      i_rst_n = 1'b0;
      idle(3);
      i_rst_n = 1'b1;
      idle(2);
      check(ctl, 8'h01);
      check({7'h00, req}, 8'h00);
      finish_test();
   end
endmodule // test_core_interrupt_control
`default_nettype wire
